// ### osdc_map.vh
`ifndef OSDC_MAP_VH
`define OSDC_MAP_VH
// Reset defaults of direct control bits
`define OSDC_RST_SCAN_STD   2'h0
`define OSDC_RST_OUT_POL    1'h1
`define OSDC_RST_DISP_EN    1'h0
`define OSDC_RST_HS_POL     1'h0
`define OSDC_RST_VS_POL     1'h0
`define OSDC_RST_SHADOW     2'h1
`define OSDC_RST_BLINK_RATE 2'h0
`define OSDC_RST_BLINK_DUTY 2'h0
`define OSDC_RST_PORT_FUNC  1'h0
`define OSDC_RST_FRAME_RGBI 4'h2
`define OSDC_RST_CMD_BANK   2'h0
// Reset defaults of indirect latches
`define OSDC_RST_CMODE      1'h0
`define OSDC_RST_CHAR_BG    4'h2
`define OSDC_RST_CHAR_SIZE  2'h0
`define OSDC_RST_EOD        1'h0
// Scan standards and shadow modes
`define OSDC_STD_CONV       2'h0
`define OSDC_STD_1050       2'h1
`define OSDC_STD_1250       2'h2
`define OSDC_SHADOW_BOX     2'h2
// Row limit arithmetic
`define OSDC_CELL_LINES     9'h012
`define OSDC_LINES_525      9'h0F1
`define OSDC_LINES_625      9'h118
`define OSDC_LINES_60HZ     1'h0
`define OSDC_LINES_50HZ     1'h1
`endif

// ### osdc_sync_in.v
`default_nettype none
// ==========================================================
// Three-stage synchroniser; change accepted when stages 2 and 3 agree
module osdc_sync_in (
    // Clock and reset
    input  wire clk,
    input  wire rst,
    // Pin and result
    input  wire din,
    output reg  dout
);
    reg s1;
    reg s2;
    reg s3;
    // Stage one is read only by stage two
    always @(posedge clk) begin
        if (rst) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // osdc_sync_in
`default_nettype wire

// ### osdc_ctrl.v
`include "osdc_map.vh"
`default_nettype none
// Behaviour
// - Row limit equals active lines per field divided by 18-line cell height.
// - 525-line standard uses 241 lines, giving at most 13 rows.
// - 625-line standard uses 280 lines, giving at most 15 rows.
// - 1050-line standard halves line-count sync internally, row limit stays 13.
// - 1250-line standard counts on undivided sync, row limit 15.
// - Scan standard select bits reset to zero, conventional scanning.
// - Output polarity resets to one, outputs active high.
// - Display enable resets to zero, display off.
// - Sync input polarity bits reset to zero, inputs active low.
// - Shadow mode resets to high 0, low 1, north-west shadowing.
// - Blink rate bits reset to zero, vsync divided by 16.
// - Blink duty bits reset to zero, on-to-off ratio three to one.
// - Port function bit resets to zero, shared pin is output port.
// - Frame background colour resets to blue.
// - Command bank select resets to bank 00.
// - Colour-mode latch resets low until a space code changes it.
// - Character background latch resets to blue until a space code loads it.
// - Character size resets to single; carriage return may load another size.
// - End-of-display resets to zero, display continues.
// - Transparent or opaque space pattern matters only in box shadowing.
// - Active-high sync setting passes hsync unchanged, active low inverts it.
module osdc_ctrl #(
    parameter OPAQUE_SPACE = 1'b1
) (
    // Clock and reset
    input  wire       CLK,
    input  wire       SYS_RST,
    // Direct control writes from the command decoder
    input  wire       CR1_WE,
    input  wire [1:0] CR1_SCAN_STD,
    input  wire       CR1_OUT_POL,
    input  wire       CR1_DISP_EN,
    input  wire       CR2_WE,
    input  wire       CR2_HS_POL,
    input  wire       CR2_VS_POL,
    input  wire [1:0] CR2_SHADOW,
    input  wire       CR3_WE,
    input  wire [1:0] CR3_BLINK_RATE,
    input  wire [1:0] CR3_BLINK_DUTY,
    input  wire       CR4_WE,
    input  wire       CR4_PORT_FUNC,
    input  wire       CR5_WE,
    input  wire [3:0] CR5_FRAME_RGBI,
    input  wire       BANK_WE,
    input  wire [1:0] BANK_SEL,
    // Indirect loads from display codes
    input  wire       SPACE_LOAD,
    input  wire       SPACE_CMODE,
    input  wire [3:0] SPACE_BG_RGBI,
    input  wire       CR_LOAD,
    input  wire [1:0] CR_CHAR_SIZE,
    input  wire       EOD_LOAD,
    input  wire       EOD_VAL,
    // Sync pins
    input  wire       HSYNC_PIN,
    input  wire       VSYNC_PIN,
    // Control state
    output reg  [1:0] SCAN_STD,
    output reg        OUT_POLARITY,
    output reg        DISP_EN,
    output reg        HSYNC_IN_POLARITY,
    output reg        VSYNC_IN_POLARITY,
    output reg        SHADOW_MODE_HI,
    output reg        SHADOW_MODE_LO,
    output reg  [1:0] BLINK_RATE,
    output reg  [1:0] BLINK_DUTY,
    output reg        PORT_FUNC,
    output reg  [3:0] FRAME_RGBI,
    output reg  [1:0] CMD_BANK,
    output reg        COLOUR_MODE_OUT,
    output reg  [3:0] CHAR_BG_RGBI,
    output reg        CHAR_SIZE_HI,
    output reg        CHAR_SIZE_LO,
    output reg        END_OF_DISPLAY,
    // Derived status
    output reg  [4:0] MAX_ROWS,
    output reg        HSYNC_ACT,
    output reg        VSYNC_ACT,
    output reg        LINE_TICK,
    output reg        SPACE_OPAQUE
);
    // ==========================================================
    // Sync input capture
    wire hs_sync;
    wire vs_sync;
    reg  hs_prev;
    reg  hdiv;
    reg  next_line_tick;

    osdc_sync_in u_hs (
        .clk  (CLK),
        .rst  (SYS_RST),
        .din  (HSYNC_PIN),
        .dout (hs_sync)
    );
    osdc_sync_in u_vs (
        .clk  (CLK),
        .rst  (SYS_RST),
        .din  (VSYNC_PIN),
        .dout (vs_sync)
    );

    // ==========================================================
    // Direct control registers
    // synchronous defaults
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SCAN_STD          <= `OSDC_RST_SCAN_STD;
            OUT_POLARITY      <= `OSDC_RST_OUT_POL;
            DISP_EN           <= `OSDC_RST_DISP_EN;
            HSYNC_IN_POLARITY <= `OSDC_RST_HS_POL;
            VSYNC_IN_POLARITY <= `OSDC_RST_VS_POL;
            {SHADOW_MODE_HI, SHADOW_MODE_LO} <= `OSDC_RST_SHADOW;
            BLINK_RATE        <= `OSDC_RST_BLINK_RATE;
            BLINK_DUTY        <= `OSDC_RST_BLINK_DUTY;
            PORT_FUNC         <= `OSDC_RST_PORT_FUNC;
            FRAME_RGBI        <= `OSDC_RST_FRAME_RGBI;
            CMD_BANK          <= `OSDC_RST_CMD_BANK;
        end else begin
            if (CR1_WE) begin
                SCAN_STD     <= CR1_SCAN_STD;
                OUT_POLARITY <= CR1_OUT_POL;
                DISP_EN      <= CR1_DISP_EN;
            end
            if (CR2_WE) begin
                HSYNC_IN_POLARITY <= CR2_HS_POL;
                VSYNC_IN_POLARITY <= CR2_VS_POL;
                {SHADOW_MODE_HI, SHADOW_MODE_LO} <= CR2_SHADOW;
            end
            if (CR3_WE) begin
                BLINK_RATE <= CR3_BLINK_RATE;
                BLINK_DUTY <= CR3_BLINK_DUTY;
            end
            if (CR4_WE) begin
                PORT_FUNC <= CR4_PORT_FUNC;
            end
            if (CR5_WE) begin
                FRAME_RGBI <= CR5_FRAME_RGBI;
            end
            if (BANK_WE) begin
                CMD_BANK <= BANK_SEL;
            end
        end
    end

    // ==========================================================
    // Indirect latches loaded by display codes
    // synchronous defaults
    always @(posedge CLK) begin
        if (SYS_RST) begin
            COLOUR_MODE_OUT <= `OSDC_RST_CMODE;
            CHAR_BG_RGBI    <= `OSDC_RST_CHAR_BG;
            {CHAR_SIZE_HI, CHAR_SIZE_LO} <= `OSDC_RST_CHAR_SIZE;
            END_OF_DISPLAY  <= `OSDC_RST_EOD;
        end else begin
            if (SPACE_LOAD) begin
                COLOUR_MODE_OUT <= SPACE_CMODE;
                CHAR_BG_RGBI    <= SPACE_BG_RGBI;
            end
            if (CR_LOAD) begin
                {CHAR_SIZE_HI, CHAR_SIZE_LO} <= CR_CHAR_SIZE;
            end
            if (EOD_LOAD) begin
                END_OF_DISPLAY <= EOD_VAL;
            end
        end
    end

    // ==========================================================
    // Row limit per standard; the integer quotient is worked out once
    // here rather than with a divider, since only two line counts exist
    // lines over cell height
    // Quotients fit in five bits; the upper bits of the 9-bit result are zero
    wire [8:0] quot_525 = `OSDC_LINES_525 / `OSDC_CELL_LINES;
    wire [8:0] quot_625 = `OSDC_LINES_625 / `OSDC_CELL_LINES;
    wire [4:0] rows_525 = quot_525[4:0];
    wire [4:0] rows_625 = quot_625[4:0];
    always @(posedge CLK) begin
        if (SYS_RST) begin
            MAX_ROWS <= 5'h00;
        end else begin
            case (SCAN_STD)
                `OSDC_STD_CONV: MAX_ROWS <= rows_525;
                `OSDC_STD_1050: MAX_ROWS <= rows_525;
                `OSDC_STD_1250: MAX_ROWS <= rows_625;
                default:        MAX_ROWS <= rows_625;
            endcase
        end
    end

    // ==========================================================
    // Sync polarity and line tick generation
    // pass or invert sync
    wire hs_act = HSYNC_IN_POLARITY ? hs_sync : ~hs_sync;
    wire vs_act = VSYNC_IN_POLARITY ? vs_sync : ~vs_sync;

    // halve line tick in 1050 mode
    always @* begin
        next_line_tick = 1'b0;
        if (hs_act && !hs_prev) begin
            if (SCAN_STD == `OSDC_STD_1050) begin
                next_line_tick = hdiv;
            end else begin
                next_line_tick = 1'b1;
            end
        end
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            // Matches hs_act while the synchroniser sits at zero, so no false tick
            hs_prev   <= 1'b1;
            hdiv      <= 1'b0;
            HSYNC_ACT <= 1'b0;
            VSYNC_ACT <= 1'b0;
            LINE_TICK <= 1'b0;
        end else begin
            hs_prev   <= hs_act;
            HSYNC_ACT <= hs_act;
            VSYNC_ACT <= vs_act;
            LINE_TICK <= next_line_tick;
            if (hs_act && !hs_prev) begin
                hdiv <= ~hdiv;
            end
            // Realign the divider each field so halving is deterministic
            if (vs_act) begin
                hdiv <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Space code pattern; opaque choice ignored outside box shadowing
    // box mode only
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SPACE_OPAQUE <= 1'b0;
        end else begin
            SPACE_OPAQUE <= OPAQUE_SPACE &&
                ({SHADOW_MODE_HI, SHADOW_MODE_LO} == `OSDC_SHADOW_BOX);
        end
    end

endmodule // osdc_ctrl
`default_nettype wire

// ### osdc_ctrl_asserts.sv
`default_nettype none
// ====
// Port checker for the control bank
module osdc_ctrl_asserts (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       SYS_RST,
    // Writes and pins
    input wire logic       CR1_WE,
    input wire logic [1:0] CR1_SCAN_STD,
    input wire logic       CR1_OUT_POL,
    input wire logic       CR1_DISP_EN,
    input wire logic       CR2_WE,
    input wire logic       CR5_WE,
    input wire logic [3:0] CR5_FRAME_RGBI,
    input wire logic       BANK_WE,
    input wire logic [1:0] BANK_SEL,
    input wire logic       HSYNC_PIN,
    // Control state
    input wire logic [1:0] SCAN_STD,
    input wire logic       OUT_POLARITY,
    input wire logic       DISP_EN,
    input wire logic       HSYNC_IN_POLARITY,
    input wire logic       SHADOW_MODE_HI,
    input wire logic       SHADOW_MODE_LO,
    input wire logic [3:0] FRAME_RGBI,
    input wire logic [1:0] CMD_BANK,
    input wire logic [4:0] MAX_ROWS,
    input wire logic       HSYNC_ACT,
    input wire logic       LINE_TICK,
    input wire logic       SPACE_OPAQUE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Defaults must already stand at the release edge, before any write lands
    a_reset_defaults: assert property ($fell(SYS_RST) |->
        {SCAN_STD, OUT_POLARITY, DISP_EN, HSYNC_IN_POLARITY, SHADOW_MODE_HI, SHADOW_MODE_LO,
        FRAME_RGBI, CMD_BANK} == 13'h0448) else $error("defaults missing after reset");
    // Writes land one edge after the strobe
    a_cr1_write: assert property (CR1_WE |=> {SCAN_STD, OUT_POLARITY, DISP_EN} ==
        $past({CR1_SCAN_STD, CR1_OUT_POL, CR1_DISP_EN})) else $error("word one not taken");
    a_frame_write: assert property (CR5_WE |=> FRAME_RGBI == $past(CR5_FRAME_RGBI))
        else $error("frame colour not taken");
    a_bank_write: assert property (BANK_WE |=> CMD_BANK == $past(BANK_SEL))
        else $error("bank not taken");
    a_shadow_hold: assert property (!CR2_WE |=> $stable({SHADOW_MODE_HI, SHADOW_MODE_LO}))
        else $error("shadow mode moved without a write");
    // Row limit follows the standard one cycle later; skipped at the release edge
    a_row_limit: assert property (!$fell(SYS_RST) |->
        MAX_ROWS == ($past(SCAN_STD[1]) ? 5'h0F : 5'h0D)) else $error("row limit wrong");
    a_opaque_box: assert property (({SHADOW_MODE_HI, SHADOW_MODE_LO} != 2'h2)[*2]
        |-> !SPACE_OPAQUE) else $error("opaque space outside box mode");
    // Eight quiet cycles cover the synchroniser delay
    a_hsync_pass: assert property (($stable(HSYNC_PIN) && $stable(HSYNC_IN_POLARITY))[*8]
        |-> HSYNC_ACT == (HSYNC_PIN ~^ HSYNC_IN_POLARITY)) else $error("hsync polarity wrong");
    // A counted line only ever follows a rising active sync
    a_tick_edge: assert property (LINE_TICK |-> $rose(HSYNC_ACT))
        else $error("line tick without sync edge");
endmodule // osdc_ctrl_asserts
bind osdc_ctrl osdc_ctrl_asserts u_chk (.*);
`default_nettype wire

// ### osdc_host.sv
`default_nettype none
// ====
// Host model: one-hot write strobes with a shared 4-bit word
module osdc_host (
    // Clock
    input  wire logic       CLK,
    // Command side
    output var  logic [5:0] we,
    output var  logic [3:0] dat
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle at time zero
    initial begin
        we = 6'h00;
        dat = 4'h0;
    end
    // One write; caller sits just after an edge, so writes may run back to back
    task cmd(input logic [2:0] idx, input logic [3:0] d);
        we <= 6'h01 << idx;
        dat <= d;
        @(posedge CLK);
    endtask
    // Released word shows its inverse so stale data never looks valid
    task idle;
        we <= 6'h00;
        dat <= ~dat;
        @(posedge CLK);
    endtask
endmodule // osdc_host
`default_nettype wire

// ### test_osd_control_reset_defaults.sv
`default_nettype none
module test_osd_control_reset_defaults;
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Stimulus and design nets
    logic CLK = 1'b0, SYS_RST = 1'b1, HSYNC_PIN = 1'b1, VSYNC_PIN = 1'b1;
    logic SPACE_LOAD = 1'b0, SPACE_CMODE = 1'b0, CR_LOAD = 1'b0, EOD_LOAD = 1'b0, EOD_VAL = 1'b0;
    logic [3:0] SPACE_BG_RGBI = 4'h0;
    logic [1:0] CR_CHAR_SIZE = 2'h0;
    logic [5:0] we;
    logic [3:0] dat;
    wire CR1_WE = we[0], CR2_WE = we[1], CR3_WE = we[2], CR4_WE = we[3], CR5_WE = we[4];
    wire BANK_WE = we[5], CR1_OUT_POL = dat[2], CR1_DISP_EN = dat[3], CR2_HS_POL = dat[0];
    wire CR2_VS_POL = dat[1], CR4_PORT_FUNC = dat[0];
    wire [1:0] CR1_SCAN_STD = dat[1:0], CR2_SHADOW = dat[3:2], CR3_BLINK_RATE = dat[1:0];
    wire [1:0] CR3_BLINK_DUTY = dat[3:2], BANK_SEL = dat[1:0];
    wire [3:0] CR5_FRAME_RGBI = dat;
    wire [1:0] SCAN_STD, BLINK_RATE, BLINK_DUTY, CMD_BANK;
    wire [3:0] FRAME_RGBI, CHAR_BG_RGBI;
    wire [4:0] MAX_ROWS;
    wire OUT_POLARITY, DISP_EN, HSYNC_IN_POLARITY, VSYNC_IN_POLARITY, SHADOW_MODE_HI;
    wire SHADOW_MODE_LO, PORT_FUNC, COLOUR_MODE_OUT, CHAR_SIZE_HI, CHAR_SIZE_LO, END_OF_DISPLAY;
    wire HSYNC_ACT, VSYNC_ACT, LINE_TICK, SPACE_OPAQUE;
    wire [18:0] st = {SCAN_STD, OUT_POLARITY, DISP_EN, HSYNC_IN_POLARITY, VSYNC_IN_POLARITY,
        SHADOW_MODE_HI, SHADOW_MODE_LO, BLINK_RATE, BLINK_DUTY, PORT_FUNC, FRAME_RGBI, CMD_BANK};
    wire [7:0] sti = {COLOUR_MODE_OUT, CHAR_BG_RGBI, CHAR_SIZE_HI, CHAR_SIZE_LO, END_OF_DISPLAY};
    int errors = 0, n_compared = 0, cyc = 0;
    logic [15:0] lf = 16'h0041;
    logic [18:0] ex;
    logic [7:0] exi;
    logic [2:0] idx;
    logic [3:0] d;
    osdc_host host (.CLK(CLK), .we(we), .dat(dat));
    osdc_ctrl dut (.*);
    // 20 MHz clock
    always #25 CLK = ~CLK;
    // ====
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Rows per field: active lines over the 18-line cell
    function automatic logic [4:0] rows(input logic [1:0] std);
        logic [8:0] n;
        n = (std[1] ? 9'h118 : 9'h0F1) / 9'h012;
        return n[4:0];
    endfunction
    task chk(input logic [18:0] seen, input logic [18:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Reset with a write issued inside it, which must be ignored
    task do_reset(input int n);
        SYS_RST <= 1'b1;
        host.cmd(3'h4, 4'hF);
        host.idle();
        repeat (n - 2) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        ex = 19'h10808;
        exi = 8'h10;
        chk(st, ex);
        chk(19'(sti), 19'(exi));
        @(posedge CLK);
        chk(19'({MAX_ROWS, SPACE_OPAQUE}), 19'({rows(2'h0), 1'b0}));
    endtask
    // Hang guard, well above the expected 612 cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            results();
        end
    end
    // ====
    // Main sequence
    initial begin
        do_reset(5);
        $display("reset test done");
        for (int i = 0; i < 60; i++) begin
            lf = lfsr(lf);
            // each word written once first, every scan standard and box mode included
            idx = (i < 4) ? 3'h0 : (i < 10) ? 3'(i - 4) : 3'(lf[7:5] % 3'h6);
            d = (i == 5) ? 4'h8 : (i < 4) ? {lf[3:2], 2'(i)} : lf[3:0];
            {SPACE_LOAD, SPACE_CMODE, SPACE_BG_RGBI, CR_LOAD, CR_CHAR_SIZE, EOD_LOAD, EOD_VAL,
                HSYNC_PIN, VSYNC_PIN} <= {lf[8], lf[9], lf[13:10], lf[14], lf[1:0], lf[15],
                lf[4], lf[6], lf[11]};
            if (lf[8]) exi[7:3] = {lf[9], lf[13:10]};
            if (lf[14]) exi[2:1] = lf[1:0];
            if (lf[15]) exi[0] = lf[4];
            case (idx)
                3'h0: ex[18:15] = {d[1:0], d[2], d[3]};
                3'h1: ex[14:11] = {d[0], d[1], d[3:2]};
                3'h2: ex[10:7] = {d[1:0], d[3:2]};
                3'h3: ex[6] = d[0];
                3'h4: ex[5:2] = d;
                default: ex[1:0] = d[1:0];
            endcase
            host.cmd(idx, d);
            {SPACE_LOAD, CR_LOAD, EOD_LOAD} <= 3'h0;
            host.idle();
            // Margin for the pin synchroniser
            repeat (8) @(posedge CLK);
            chk(st, ex);
            chk(19'(MAX_ROWS), 19'(rows(ex[18:17])));
            chk(19'(sti), 19'(exi));
            chk(19'(SPACE_OPAQUE), 19'(ex[12:11] == 2'h2));
            chk(19'({HSYNC_ACT, VSYNC_ACT}), 19'({lf[6] ~^ ex[14], lf[11] ~^ ex[13]}));
        end
        $display("write test done");
        do_reset(3);
        $display("second reset test done");
        results();
    end
endmodule // test_osd_control_reset_defaults
`default_nettype wire
